// >>> hdl/dtfg_pkg.sv
package dtfg_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dtfg_bus_req_t;
    typedef struct packed {
        logic signed [9:0] sample;
        logic              active;
        logic              square;
    } dtfg_synth_out_t;
endpackage

// >>> hdl/dtfg_regs.svh
`ifndef DTFG_REGS_SVH
`define DTFG_REGS_SVH
`define DTFG_ADDR_HIGH_CODE  8'h11
`define DTFG_ADDR_LOW_CODE   8'h12
`define DTFG_ADDR_MELODY_CTL 8'h13
`define DTFG_ADDR_STATUS     8'h14
`define DTFG_MELODY_EN_BIT   0
`define DTFG_RESET_CODE      8'h00
`define DTFG_RESET_MELODY    1'b0
`define DTFG_STEPS           5'd23
`define DTFG_HIGH_STEPS      5'd12
`define DTFG_CODE_OFFSET     9'd2
`define DTFG_MELODY_MIN_CODE 8'h02
`define DTFG_TONE_MIN_CODE   8'h3c
`endif

// >>> hdl/dtfg_synth.sv
`timescale 1ns/10ps
`include "dtfg_regs.svh"
module dtfg_synth #(
    parameter int AMP_NUM = 128
) (
    input  wire logic                     clk_in,
    input  wire logic                     arst_n_in,
    input  wire logic [7:0]               code_in,
    output dtfg_pkg::dtfg_synth_out_t     synth_out
);
    import dtfg_pkg::*;

    logic [8:0] div_reg;
    logic [4:0] step_reg;
    logic       run;
    logic       step_done;
    logic [8:0] div_last;
    logic signed [7:0] sine_raw;
    logic signed [16:0] scaled;
    dtfg_synth_out_t out_reg;
    dtfg_synth_out_t out_next;

    // 23-point sine, peak 127
    function automatic logic signed [7:0] sine_lut(input logic [4:0] idx);
        logic signed [7:0] v;
        v = 8'sh00;
        unique case (idx)
            5'd0:    v = 8'sh00;
            5'd1:    v = 8'sh22;
            5'd2:    v = 8'sh42;
            5'd3:    v = 8'sh5e;
            5'd4:    v = 8'sh72;
            5'd5:    v = 8'sh7d;
            5'd6:    v = 8'sh7f;
            5'd7:    v = 8'sh77;
            5'd8:    v = 8'sh66;
            5'd9:    v = 8'sh4d;
            5'd10:   v = 8'sh2e;
            5'd11:   v = 8'sh0b;
            5'd12:   v = 8'shf5;
            5'd13:   v = 8'shd2;
            5'd14:   v = 8'shb3;
            5'd15:   v = 8'sh9a;
            5'd16:   v = 8'sh89;
            5'd17:   v = 8'sh81;
            5'd18:   v = 8'sh83;
            5'd19:   v = 8'sh8e;
            5'd20:   v = 8'sha2;
            5'd21:   v = 8'shbe;
            5'd22:   v = 8'she0;
            default: v = 8'sh00;
        endcase
        return v;
    endfunction

    assign run       = (code_in != `DTFG_RESET_CODE);
    assign div_last  = {1'b0, code_in} + `DTFG_CODE_OFFSET - 9'd1;
    assign step_done = run && (div_reg >= div_last);
    assign sine_raw  = sine_lut(step_reg);
    assign scaled    = 17'(sine_raw * $signed(9'(AMP_NUM)));
    assign out_next.active = run;
    assign out_next.sample = run ? 10'(scaled >>> 7) : 10'sd0;
    assign out_next.square = run && (step_reg < `DTFG_HIGH_STEPS);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_reg  <= 9'd0;
            step_reg <= 5'd0;
            out_reg  <= '0;
        end else begin
            out_reg <= out_next;
            if (!run) begin
                div_reg  <= 9'd0;
                step_reg <= 5'd0;
            end else if (step_done) begin
                div_reg  <= 9'd0;
                step_reg <= (step_reg == `DTFG_STEPS - 5'd1) ? 5'd0 : step_reg + 5'd1;
            end else begin
                div_reg <= div_reg + 9'd1;
            end
        end
    end

    assign synth_out = out_reg;
endmodule // dtfg_synth

// >>> hdl/dtfg_top.sv
`timescale 1ns/10ps
`include "dtfg_regs.svh"
// What this block does
// - Melody square is high 12 of every 23 steps at high group rate.
// - Melody accepts high codes from 2; sine tone codes should be at least 60.
// - Sine tone keeps running from the high code while melody is active.
// - Two independent sine synthesizers, high and low code, summed.
// - Low group amplitude is 2 dB below high group amplitude.
// - A code of zero stops its synthesizer.
// - Both codes zero shuts the whole generator off.
// - Output frequency is clock over 23 times code plus two.
// - Tone output is high impedance while no tone is generated.
// - High code write-only at 11h, low code write-only at 12h.
// - Melody enable picks port line or melody; port writes still work.
// - Melody enabled with high code zero holds the pin high.
module dtfg_top #(
    parameter int LOW_AMP = 102
) (
    input  wire logic                  clk_in,
    input  wire logic                  arst_n_in,
    input  dtfg_pkg::dtfg_bus_req_t    bus_in,
    output logic [7:0]                 rdata_out,
    input  wire logic                  port_ff_in,
    input  wire logic                  melody_pin_in,
    output logic                       melody_pin_o_out,
    output logic                       melody_pin_oe_out,
    output logic                       pin_level_out,
    output logic signed [10:0]         tone_out,
    output logic                       tone_oe_out,
    output logic                       gen_on_out
);
    import dtfg_pkg::*;

    logic [7:0]        high_group_code_reg;
    logic [7:0]        low_group_code_reg;
    logic              melody_enable_reg;
    logic [7:0]        rdata_reg;
    logic [7:0]        rdata_next;
    logic              pin_sync1_reg;
    logic              pin_sync2_reg;
    logic              melody_reg;
    logic              melody_next;
    logic signed [10:0] tone_reg;
    logic signed [10:0] tone_next;
    logic              tone_oe_reg;
    logic              gen_on;
    logic              wr_high;
    logic              wr_low;
    logic              wr_ctl;
    dtfg_synth_out_t   high_syn;
    dtfg_synth_out_t   low_syn;

    function automatic logic hit(input dtfg_bus_req_t b, input logic [7:0] a);
        return b.addr == a;
    endfunction

    assign wr_high = bus_in.wr && hit(bus_in, `DTFG_ADDR_HIGH_CODE);
    assign wr_low  = bus_in.wr && hit(bus_in, `DTFG_ADDR_LOW_CODE);
    assign wr_ctl  = bus_in.wr && hit(bus_in, `DTFG_ADDR_MELODY_CTL);

    // Code registers are write-only and read as zero
    assign rdata_next =
        !bus_in.rd ? 8'h00 :
        hit(bus_in, `DTFG_ADDR_MELODY_CTL) ? {7'h00, melody_enable_reg} :
        hit(bus_in, `DTFG_ADDR_STATUS) ?
            {4'h0, melody_reg, low_syn.active, high_syn.active, gen_on} : 8'h00;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            high_group_code_reg <= `DTFG_RESET_CODE;
            low_group_code_reg  <= `DTFG_RESET_CODE;
            melody_enable_reg   <= `DTFG_RESET_MELODY;
            rdata_reg           <= 8'h00;
        end else begin
            if (wr_high) high_group_code_reg <= bus_in.wdata;
            if (wr_low)  low_group_code_reg  <= bus_in.wdata;
            if (wr_ctl)  melody_enable_reg   <= bus_in.wdata[`DTFG_MELODY_EN_BIT];
            rdata_reg <= rdata_next;
        end
    end

    dtfg_synth #(.AMP_NUM(128)) u_high (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .code_in   (high_group_code_reg),
        .synth_out (high_syn)
    );

    // 102/128 is about -1.97 dB
    dtfg_synth #(.AMP_NUM(LOW_AMP)) u_low (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .code_in   (low_group_code_reg),
        .synth_out (low_syn)
    );

    assign gen_on = high_syn.active || low_syn.active;
    // Sine is summed for any nonzero code; low codes are filtered off-chip
    assign tone_next = gen_on ? (11'(high_syn.sample) + 11'(low_syn.sample)) : 11'sd0;

    // Melody path: any nonzero code, even 2, drives the square
    assign melody_next = (high_group_code_reg == `DTFG_RESET_CODE) ? 1'b1 : high_syn.square;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tone_reg      <= 11'sd0;
            tone_oe_reg   <= 1'b0;
            melody_reg    <= 1'b1;
            pin_sync1_reg <= 1'b1;
            pin_sync2_reg <= 1'b1;
        end else begin
            tone_reg      <= tone_next;
            tone_oe_reg   <= gen_on;
            melody_reg    <= melody_next;
            pin_sync1_reg <= melody_pin_in;
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    // Quasi-bidirectional: drive only a low; port flip-flop must stay high
    assign melody_pin_o_out  = melody_enable_reg ? (melody_reg & port_ff_in) : port_ff_in;
    assign melody_pin_oe_out = !melody_pin_o_out;
    assign pin_level_out     = pin_sync2_reg;
    assign tone_out          = tone_reg;
    assign tone_oe_out       = tone_oe_reg;
    assign gen_on_out        = gen_on;
    assign rdata_out         = rdata_reg;
endmodule // dtfg_top

// >>> verification/dtfg_asserts.sv
`timescale 1ns/10ps
module dtfg_asserts (
    input wire logic             clk_in,
    input wire logic             arst_n_in,
    input dtfg_pkg::dtfg_bus_req_t bus_in,
    input wire logic [7:0]       rdata_out,
    input wire logic             port_ff_in,
    input wire logic             melody_pin_in,
    input wire logic             melody_pin_o_out,
    input wire logic             melody_pin_oe_out,
    input wire logic             pin_level_out,
    input wire logic             tone_oe_out,
    input wire logic             gen_on_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    chk_code_read_zero:
        assert property (bus_in.rd && bus_in.addr inside {8'h11, 8'h12} |=> rdata_out == 8'h00)
        else $error("code register read back");
    chk_rdata_idle:
        assert property (!bus_in.rd |=> rdata_out == 8'h00) else $error("rdata not idle");
    chk_ctl_upper_zero:
        assert property (bus_in.rd && bus_in.addr == 8'h13 |=> rdata_out[7:1] == 7'h00)
        else $error("control upper bits set");
    chk_gen_shutoff:
        assert property ($fell(gen_on_out) |-> ##[1:3] !tone_oe_out) else $error("tone stays on");
    chk_pin_drive_sense:
        assert property (melody_pin_oe_out == !melody_pin_o_out) else $error("pin enable wrong");
    chk_idle_pin_high:
        assert property (!gen_on_out [*3] |-> melody_pin_o_out == port_ff_in)
        else $error("idle pin level wrong");
    chk_tone_needs_code:
        assert property ($rose(tone_oe_out) |-> $past(gen_on_out)) else $error("tone without code");
    chk_pin_sync:
        assert property ($stable(melody_pin_in) [*3] |-> pin_level_out == melody_pin_in)
        else $error("pin level not synced");
    chk_port_low_drive:
        assert property (!port_ff_in |-> melody_pin_oe_out) else $error("port low not driven");
    chk_tone_off_idle:
        assert property (!gen_on_out |=> !tone_oe_out) else $error("tone pin driven while idle");
endmodule // dtfg_asserts
bind dtfg_top dtfg_asserts u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus_in),
    .rdata_out(rdata_out), .port_ff_in(port_ff_in), .melody_pin_in(melody_pin_in),
    .melody_pin_o_out(melody_pin_o_out), .melody_pin_oe_out(melody_pin_oe_out),
    .pin_level_out(pin_level_out), .tone_oe_out(tone_oe_out), .gen_on_out(gen_on_out));

// >>> verification/dtfg_sw_model.sv
`timescale 1ns/10ps
module dtfg_sw_model (
    input  wire logic              clk_in,
    input  wire logic [7:0]        rdata_in,
    output dtfg_pkg::dtfg_bus_req_t bus_out
);
    initial bus_out = '0;
    // Idle cycle after each access keeps one assignment per time step
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        bus_out <= '{a, d, w, !w};
        @(posedge clk_in);
        bus_out <= '0;
        @(posedge clk_in);
        q = rdata_in;
    endtask
endmodule // dtfg_sw_model

// >>> verification/dtfg_top_tb.sv
`timescale 1ns/10ps
module dtfg_top_tb;
    import dtfg_pkg::*;
    logic               clk_in = 1'b0;
    logic               arst_n_in = 1'b0;
    logic               port_ff = 1'b1;
    dtfg_bus_req_t      bus;
    logic [7:0]         rdata, q;
    logic               pin_o, pin_oe, pin_lvl, tone_oe, gen_on;
    logic signed [10:0] tone;
    int                 err_total = 0, samples_checked = 0, n, h, l;
    logic [23:0]        rows [5] = '{24'h117f00, 24'h12dd00, 24'h130101, 24'h13ff01, 24'h155500};
    logic [7:0]         codes [5] = '{8'h02, 8'h5d, 8'ha3, 8'h3c, 8'h3d};
    always #5 clk_in = ~clk_in;
    dtfg_sw_model sw (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));
    // Pin has a pull-up: released means high
    dtfg_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus), .rdata_out(rdata),
        .port_ff_in(port_ff), .melody_pin_in(!pin_oe), .melody_pin_o_out(pin_o),
        .melody_pin_oe_out(pin_oe), .pin_level_out(pin_lvl), .tone_out(tone),
        .tone_oe_out(tone_oe), .gen_on_out(gen_on));
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wt(input logic v, inout int c);
        while (pin_o !== v && n < 9000) begin
            @(posedge clk_in);
            n++;
            c++;
        end
        if (n >= 9000) begin
            err_total++;
            stop_test();
        end
    endtask
    // Window spans more than one full period of the slowest code used with it
    task automatic peak(output int m);
        m = 0;
        repeat (4000) begin
            @(posedge clk_in);
            if (tone > m) m = tone;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        arst_n_in <= 1'b1;
        chk(tone_oe, 0);
        for (int i = 0; i < 5; i++) begin
            sw.acc(1'b1, rows[i][23:16], rows[i][15:8], q);
            sw.acc(1'b0, rows[i][23:16], 8'h00, q);
            chk(q, rows[i][7:0]);
        end
        chk({gen_on, tone_oe}, 2'b11);
        $display("register test done");
        for (int i = 0; i < 5; i++) begin
            sw.acc(1'b1, 8'h11, codes[i], q);
            n = 0;
            h = 0;
            l = 0;
            wt(1'b0, n);
            wt(1'b1, n);
            wt(1'b0, h);
            wt(1'b1, l);
            chk(h, 12 * (codes[i] + 2));
            chk(l, 11 * (codes[i] + 2));
            chk(tone_oe, 1);
        end
        $display("melody test done");
        port_ff <= 1'b0;
        sw.acc(1'b1, 8'h13, 8'h00, q);
        // Pin level comes through two sync stages
        @(posedge clk_in);
        chk({pin_o, pin_lvl}, 2'b00);
        port_ff <= 1'b1;
        sw.acc(1'b1, 8'h11, 8'h00, q);
        chk({gen_on, tone_oe}, 2'b11);
        sw.acc(1'b0, 8'h14, 8'h00, q);
        chk(q, 8'h0d);
        sw.acc(1'b1, 8'h12, 8'h00, q);
        sw.acc(1'b1, 8'h13, 8'h01, q);
        chk({gen_on, tone_oe, pin_o, pin_lvl}, 4'b0011);
        chk(tone, 0);
        $display("shutoff test done");
        sw.acc(1'b1, 8'h11, 8'h44, q);
        peak(h);
        sw.acc(1'b1, 8'h11, 8'h00, q);
        sw.acc(1'b1, 8'h12, 8'ha3, q);
        peak(l);
        // 2 dB is a ratio of about 0.794
        chk(l * 1000 >= h * 784 && l * 1000 <= h * 804 && h > 0, 1);
        $display("tone test done");
        sw.acc(1'b1, 8'h12, 8'h5d, q);
        arst_n_in <= 1'b0;
        @(posedge clk_in);
        chk({gen_on, tone_oe}, 2'b00);
        repeat (3) @(posedge clk_in);
        arst_n_in <= 1'b1;
        sw.acc(1'b0, 8'h13, 8'h00, q);
        chk(q, 8'h00);
        sw.acc(1'b0, 8'h14, 8'h00, q);
        chk(q, 8'h08);
        $display("reset test done");
        stop_test();
    end
endmodule // dtfg_top_tb
